// File: hdl/enhanced_waveform_unit_pkg.sv
// Package: register map, field layout, reset values and codes of the
// enhanced capture/compare/PWM unit.
// Assumes one 25 MHz clock that stands for the oscillator clock.
package enhanced_waveform_unit_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] OFF_TIMER_COUNT  = 4'h0;
    localparam logic [3:0] OFF_PERIOD_LIMIT = 4'h1;
    localparam logic [3:0] OFF_TIMER_CTRL   = 4'h2;
    localparam logic [3:0] OFF_DUTY_LOW     = 4'h3;
    localparam logic [3:0] OFF_DUTY_BUFFER  = 4'h4;
    localparam logic [3:0] OFF_UNIT_CTRL    = 4'h5;
    localparam logic [3:0] OFF_STATUS       = 4'h6;
    localparam logic [3:0] OFF_PORT_LATCH   = 4'h7;
    localparam logic [3:0] OFF_PORT_DIR     = 4'h8;

    // Reset values
    localparam logic [7:0] RST_TIMER_COUNT  = 8'h00;
    localparam logic [7:0] RST_PERIOD_LIMIT = 8'hFF;
    localparam logic [6:0] RST_TIMER_CTRL   = 7'h00;
    localparam logic [7:0] RST_DUTY         = 8'h00;
    localparam logic [7:0] RST_UNIT_CTRL    = 8'h00;
    localparam logic [3:0] RST_PORT_LATCH   = 4'h0;
    localparam logic [3:0] RST_PORT_DIR     = 4'hF;

    // Unit control fields
    localparam int STEER_HI = 7;
    localparam int STEER_LO = 6;
    localparam int DLSB_HI  = 5;
    localparam int DLSB_LO  = 4;
    localparam int MODE_HI  = 3;
    localparam int MODE_LO  = 0;
    localparam int POL_AC   = 1;
    localparam int POL_BD   = 0;

    // Timer control fields
    localparam int POST_HI  = 6;
    localparam int POST_LO  = 3;
    localparam int RUN_BIT  = 2;
    localparam int PRE_HI   = 1;
    localparam int PRE_LO   = 0;

    // Status fields
    localparam int MATCH_FLAG_BIT  = 0;
    localparam int PERIOD_FLAG_BIT = 1;

    // Mode codes
    localparam logic [3:0] MODE_OFF         = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE  = 4'h2;
    localparam logic [3:0] MODE_CAP_FALL    = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE    = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4   = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16  = 4'h7;
    localparam logic [3:0] MODE_CMP_SET     = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR   = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT    = 4'hA;
    localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;

    // Steering codes
    localparam logic [1:0] STEER_SINGLE   = 2'h0;
    localparam logic [1:0] STEER_FULL_FWD = 2'h1;
    localparam logic [1:0] STEER_HALF     = 2'h2;
    localparam logic [1:0] STEER_FULL_REV = 2'h3;

    // Prescale codes; 2 and 3 both divide by sixteen
    localparam logic [1:0] PRE_DIV1 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;

    // One instruction cycle is four oscillator periods
    localparam int         QUARTERS     = 4;
    localparam logic [5:0] PRESC_TOP1   = 6'(QUARTERS * 1 - 1);
    localparam logic [5:0] PRESC_TOP4   = 6'(QUARTERS * 4 - 1);
    localparam logic [5:0] PRESC_TOP16  = 6'(QUARTERS * 16 - 1);

    // Edge counts of the counting capture modes
    localparam logic [3:0] CAP_LAST4    = 4'h3;
    localparam logic [3:0] CAP_LAST16   = 4'hF;

    typedef enum logic [1:0] {
        CLS_OFF     = 2'b00,
        CLS_CAPTURE = 2'b01,
        CLS_COMPARE = 2'b11,
        CLS_PWM     = 2'b10
    } unit_class_t;

    // Reserved codes fall into the off class: pins stay port pins
    function automatic unit_class_t classify(input logic [3:0] mode);
        unit_class_t c;
        c = CLS_OFF;
        case (mode)
            4'h4, 4'h5, 4'h6, 4'h7: c = CLS_CAPTURE;
            4'h2, 4'h8, 4'h9, 4'hA, 4'hB: c = CLS_COMPARE;
            4'hC, 4'hD, 4'hE, 4'hF: c = CLS_PWM;
            default: c = CLS_OFF;
        endcase
        return c;
    endfunction

endpackage

// File: hdl/waveform_if.sv
// Interface: waveform and port state from the unit core to the pin stage.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ns
interface waveform_if;
    import enhanced_waveform_unit_pkg::*;
    unit_class_t cls;
    logic [3:0]  mode;
    logic [1:0]  steer;
    logic [1:0]  pol;
    logic        pwm_level;
    logic        cmp_level;
    logic [3:0]  port_latch;
    logic [3:0]  port_dir;

    modport source (output cls, mode, steer, pol, pwm_level, cmp_level,
                    port_latch, port_dir);
    modport sink   (input  cls, mode, steer, pol, pwm_level, cmp_level,
                    port_latch, port_dir);
endinterface

// File: hdl/pin_steering.sv
// Pin stage: maps PWM, compare level and port latch onto outputs A-D.
// Assumes all inputs come from flip-flops of the unit core.
`timescale 1ns/1ns
module pin_steering
    import enhanced_waveform_unit_pkg::*;
(
    waveform_if.sink   wf,
    output wire logic [3:0] pin_out,
    output wire logic [3:0] pin_oe
);

    typedef enum logic [2:0] {
        ROLE_PORT, ROLE_MOD, ROLE_MOD_N, ROLE_ACTIVE, ROLE_INACTIVE, ROLE_UNIT
    } pin_role_t;

    pin_role_t  role [4];
    logic [3:0] level;
    logic [3:0] drv;
    logic [3:0] oe;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            role[i] = ROLE_PORT;
        end
        if (wf.cls == CLS_PWM) begin
            case (wf.steer)
                STEER_SINGLE: role[0] = ROLE_MOD;
                STEER_FULL_FWD: begin
                    role[0] = ROLE_ACTIVE;
                    role[1] = ROLE_INACTIVE;
                    role[2] = ROLE_INACTIVE;
                    role[3] = ROLE_MOD;
                end
                STEER_HALF: begin
                    role[0] = ROLE_MOD;
                    role[1] = ROLE_MOD_N;
                end
                STEER_FULL_REV: begin
                    role[0] = ROLE_INACTIVE;
                    role[1] = ROLE_MOD;
                    role[2] = ROLE_ACTIVE;
                    role[3] = ROLE_INACTIVE;
                end
                default: role[0] = ROLE_MOD;
            endcase
        end else if (wf.cls == CLS_COMPARE &&
                     wf.mode != MODE_CMP_SOFT) begin
            role[0] = ROLE_UNIT;
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            case (role[i])
                ROLE_MOD:      level[i] = wf.pwm_level;
                ROLE_MOD_N:    level[i] = ~wf.pwm_level;
                ROLE_ACTIVE:   level[i] = 1'b1;
                ROLE_INACTIVE: level[i] = 1'b0;
                default:       level[i] = 1'b0;
            endcase
            // A and C share one polarity bit, B and D the other
            if (role[i] == ROLE_PORT) begin
                drv[i] = wf.port_latch[i];
            end else if (role[i] == ROLE_UNIT) begin
                drv[i] = wf.cmp_level;
            end else begin
                drv[i] = level[i] ^ wf.pol[(i % 2 == 0) ? 1 : 0];
            end
            // The direction bits still gate every pin, unit-driven or not
            oe[i] = ~wf.port_dir[i];
        end
    end

    assign pin_out = drv;
    assign pin_oe  = oe;

endmodule

// File: hdl/enhanced_waveform_unit_unit.sv
// Enhanced capture/compare/PWM unit with its 8-bit period timer.
// Assumes synchronous inputs on CLK and a master that follows the
// one-cycle strobe protocol of the plain register port.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
module enhanced_waveform_unit_unit
    import enhanced_waveform_unit_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESET,
    input  wire logic [3:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output wire logic [7:0]  RDATA,
    input  wire logic [15:0] CAPTURE_TIMER,
    input  wire logic        CONVERTER_ENABLE,
    input  wire logic [3:0]  PIN_IN,
    output wire logic [3:0]  PIN_OUT,
    output wire logic [3:0]  PIN_OE,
    output wire logic        MATCH_FLAG,
    output wire logic        TIMER_RESET,
    output wire logic        CONVERT_START
);

    typedef struct packed {
        logic [7:0] timer;
        logic [7:0] period;
        logic [6:0] tctrl;
        logic [5:0] presc;
        logic [3:0] post;
        logic [7:0] duty_low;
        logic [7:0] duty_buf;
        logic [1:0] duty_lsb_buf;
        logic [7:0] ctrl;
        logic [1:0] steer_q;
        logic [1:0] pol_q;
        logic       pwm_level;
        logic       cmp_level;
        logic       cmp_hit_prev;
        logic       cap_prev;
        logic [3:0] cap_count;
        logic       match_flag;
        logic       period_flag;
        logic [3:0] port_latch;
        logic [3:0] port_dir;
        logic [7:0] rdata;
        logic       timer_reset;
        logic       convert_start;
    } state_t;

    state_t      s;
    state_t      next_s;
    unit_class_t cls;
    logic [3:0]  mode;
    logic [5:0]  presc_top;
    logic        run;
    logic        tick;
    logic        period_end;
    logic [1:0]  next_fine;
    logic [9:0]  duty_next;
    logic        rise;
    logic        fall;
    logic        cap_event;
    logic        cmp_hit;
    logic        cmp_event;
    logic        set_match;
    logic        set_period;
    logic [1:0]  clr_status;
    logic [7:0]  rd_mux;

    // Quarter-cycle phase: the prescaler bits that step once per duty unit
    function automatic logic [1:0] phase_of(input logic [1:0] sel,
                                            input logic [5:0] p);
        logic [1:0] f;
        case (sel)
            PRE_DIV1: f = p[1:0];
            PRE_DIV4: f = p[3:2];
            default:  f = p[5:4];
        endcase
        return f;
    endfunction

    always_comb begin
        next_s = s;
        next_s.timer_reset   = 1'b0;
        next_s.convert_start = 1'b0;
        mode = s.ctrl[MODE_HI:MODE_LO];
        cls  = classify(mode);
        run  = s.tctrl[RUN_BIT];
        set_match  = 1'b0;
        set_period = 1'b0;

        // Prescaler counts oscillator clocks; its top two counting bits double as the
        // quarter-cycle phase, so one counter serves both purposes
        case (s.tctrl[PRE_HI:PRE_LO])
            PRE_DIV1: presc_top = PRESC_TOP1;
            PRE_DIV4: presc_top = PRESC_TOP4;
            default:  presc_top = PRESC_TOP16;
        endcase
        tick       = run && (s.presc == presc_top);
        period_end = tick && (s.timer == s.period);
        duty_next  = {s.duty_low, s.ctrl[DLSB_HI:DLSB_LO]};

        if (run) begin
            next_s.presc = tick ? 6'h00 : s.presc + 6'h01;
        end
        if (tick) begin
            next_s.timer = period_end ? 8'h00 : s.timer + 8'h01;
        end

        // Postscaler only paces the period flag, never the waveform
        if (period_end) begin
            if (s.post == s.tctrl[POST_HI:POST_LO]) begin
                next_s.post = 4'h0;
                set_period  = 1'b1;
            end else begin
                next_s.post = s.post + 4'h1;
            end
        end

        // PWM waveform
        if (cls == CLS_PWM) begin
            // Equality only: a duty beyond the period never matches.
            // The count of the next clock is compared, so the level is
            // high for exactly the duty value, not one clock more.
            next_fine = phase_of(s.tctrl[PRE_HI:PRE_LO], next_s.presc);
            if ({next_s.timer, next_fine} ==
                {s.duty_buf, s.duty_lsb_buf}) begin
                next_s.pwm_level = 1'b0;
            end
            if (period_end) begin
                next_s.duty_buf     = s.duty_low;
                next_s.duty_lsb_buf = s.ctrl[DLSB_HI:DLSB_LO];
                next_s.pwm_level    = (duty_next != 10'h000);
                next_s.steer_q      = s.ctrl[STEER_HI:STEER_LO];
                next_s.pol_q        = {s.ctrl[POL_AC], s.ctrl[POL_BD]};
            end
        end else begin
            next_fine        = 2'h0;
            next_s.pwm_level = 1'b0;
        end

        // Capture input edges on output A's pin
        next_s.cap_prev = PIN_IN[0];
        rise = PIN_IN[0] && !s.cap_prev;
        fall = !PIN_IN[0] && s.cap_prev;
        cap_event = 1'b0;
        if (cls == CLS_CAPTURE) begin
            case (mode)
                MODE_CAP_FALL: cap_event = fall;
                MODE_CAP_RISE: cap_event = rise;
                MODE_CAP_RISE4: begin
                    if (rise) begin
                        cap_event        = (s.cap_count == CAP_LAST4);
                        next_s.cap_count = cap_event ? 4'h0
                                                     : s.cap_count + 4'h1;
                    end
                end
                MODE_CAP_RISE16: begin
                    if (rise) begin
                        cap_event        = (s.cap_count == CAP_LAST16);
                        next_s.cap_count = s.cap_count + 4'h1;
                    end
                end
                default: cap_event = 1'b0;
            endcase
        end
        if (cap_event) begin
            next_s.duty_buf = CAPTURE_TIMER[15:8];
            next_s.duty_low = CAPTURE_TIMER[7:0];
            set_match       = 1'b1;
        end

        // Compare: act once when the timer first meets the value
        cmp_hit = (CAPTURE_TIMER == {s.duty_buf, s.duty_low});
        next_s.cmp_hit_prev = cmp_hit;
        cmp_event = (cls == CLS_COMPARE) && cmp_hit && !s.cmp_hit_prev;
        if (cmp_event) begin
            set_match = 1'b1;
            case (mode)
                MODE_CMP_TOGGLE: next_s.cmp_level = ~s.cmp_level;
                MODE_CMP_SET:    next_s.cmp_level = 1'b1;
                MODE_CMP_CLEAR:  next_s.cmp_level = 1'b0;
                MODE_CMP_SPECIAL: begin
                    next_s.timer_reset   = 1'b1;
                    next_s.convert_start = CONVERTER_ENABLE;
                end
                default: next_s.cmp_level = s.cmp_level;
            endcase
        end

        // Off mode parks the levels, capture count, steering, polarity and duty LSB buffer
        if (mode == MODE_OFF) begin
            next_s.pwm_level    = 1'b0;
            next_s.cmp_level    = 1'b0;
            next_s.cap_count    = 4'h0;
            next_s.steer_q      = STEER_SINGLE;
            next_s.pol_q        = 2'h0;
            next_s.duty_lsb_buf = 2'h0;
        end

        // Register writes; data writes win over hardware updates, but flag sets beat status clears
        clr_status = 2'h0;
        if (WR) begin
            case (ADDR)
                OFF_TIMER_COUNT: begin
                    next_s.timer = WDATA;
                    next_s.presc = 6'h00;
                end
                OFF_PERIOD_LIMIT: next_s.period = WDATA;
                OFF_TIMER_CTRL: begin
                    next_s.tctrl = WDATA[6:0];
                    next_s.post  = 4'h0;
                end
                OFF_DUTY_LOW: next_s.duty_low = WDATA;
                OFF_DUTY_BUFFER: begin
                    // Read-only in PWM, where the period end owns it
                    if (cls != CLS_PWM) begin
                        next_s.duty_buf = WDATA;
                    end
                end
                OFF_UNIT_CTRL: begin
                    next_s.ctrl = WDATA;
                    if (classify(WDATA[MODE_HI:MODE_LO]) != cls) begin
                        next_s.cap_count = 4'h0;
                    end
                end
                OFF_STATUS: clr_status = {WDATA[PERIOD_FLAG_BIT],
                                          WDATA[MATCH_FLAG_BIT]};
                OFF_PORT_LATCH: next_s.port_latch = WDATA[3:0];
                OFF_PORT_DIR:   next_s.port_dir   = WDATA[3:0];
                default: clr_status = 2'h0;
            endcase
        end

        // Flags clear on a written one; a same-cycle event still sets
        next_s.match_flag  = set_match | (s.match_flag & ~clr_status[0]);
        next_s.period_flag = set_period | (s.period_flag & ~clr_status[1]);

        // Read data stands only in the cycle after the strobe
        case (ADDR)
            OFF_TIMER_COUNT:  rd_mux = s.timer;
            OFF_PERIOD_LIMIT: rd_mux = s.period;
            OFF_TIMER_CTRL:   rd_mux = {1'b0, s.tctrl};
            OFF_DUTY_LOW:     rd_mux = s.duty_low;
            OFF_DUTY_BUFFER:  rd_mux = s.duty_buf;
            OFF_UNIT_CTRL:    rd_mux = s.ctrl;
            OFF_STATUS:       rd_mux = {6'h00, s.period_flag, s.match_flag};
            OFF_PORT_LATCH:   rd_mux = {4'h0, s.port_latch};
            OFF_PORT_DIR:     rd_mux = {4'h0, s.port_dir};
            default:          rd_mux = 8'h00;
        endcase
        next_s.rdata = RD ? rd_mux : 8'h00;
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            s              <= '0;
            s.timer        <= RST_TIMER_COUNT;
            s.period       <= RST_PERIOD_LIMIT;
            s.tctrl        <= RST_TIMER_CTRL;
            s.duty_low     <= RST_DUTY;
            s.duty_buf     <= RST_DUTY;
            s.ctrl         <= RST_UNIT_CTRL;
            s.port_latch   <= RST_PORT_LATCH;
            s.port_dir     <= RST_PORT_DIR;
        end else begin
            s <= next_s;
        end
    end

    waveform_if wf ();

    assign wf.cls        = classify(s.ctrl[MODE_HI:MODE_LO]);
    assign wf.mode       = s.ctrl[MODE_HI:MODE_LO];
    assign wf.steer      = s.steer_q;
    assign wf.pol        = s.pol_q;
    assign wf.pwm_level  = s.pwm_level;
    assign wf.cmp_level  = s.cmp_level;
    assign wf.port_latch = s.port_latch;
    assign wf.port_dir   = s.port_dir;

    pin_steering u_pins (
        .wf      (wf.sink),
        .pin_out (PIN_OUT),
        .pin_oe  (PIN_OE)
    );

    assign RDATA         = s.rdata;
    assign MATCH_FLAG    = s.match_flag;
    assign TIMER_RESET   = s.timer_reset;
    assign CONVERT_START = s.convert_start;

endmodule

// File: bench/switch_load.sv
// Partner: switch drivers and loads hanging on outputs A-D.
// Assumes pull-downs on B-D; A may be driven from outside when released.
`timescale 1ns/1ns
module switch_load (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    input  wire logic       ext_level,
    output wire logic [3:0] pin_level
);
    // A released pin must not keep the last driven value
    assign pin_level[0]   = pin_oe[0] ? pin_out[0] : ext_level;
    assign pin_level[3:1] = pin_out[3:1] & pin_oe[3:1];
endmodule

// File: bench/enhanced_waveform_unit_unit_properties.sv
// Checker: port relations of the capture/compare/PWM unit.
// Assumes a bind onto enhanced_waveform_unit_unit; control shadows follow seen writes.
`timescale 1ns/1ns
module enhanced_waveform_unit_unit_properties
    import enhanced_waveform_unit_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RESET,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       CONVERTER_ENABLE,
    input wire logic [3:0] PIN_OUT,
    input wire logic [3:0] PIN_OE,
    input wire logic       MATCH_FLAG,
    input wire logic       TIMER_RESET,
    input wire logic       CONVERT_START
);
    logic [7:0] ctrl;
    logic [3:0] latch;
    wire  [3:0] mode = ctrl[3:0];
    wire  [3:0] wlow = WDATA[3:0];
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ctrl  <= RST_UNIT_CTRL;
            latch <= RST_PORT_LATCH;
        end else if (WR && ADDR == OFF_UNIT_CTRL) begin
            ctrl <= WDATA;
        end else if (WR && ADDR == OFF_PORT_LATCH) begin
            latch <= wlow;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_reset_clear: assert property ($fell(RESET) |->
        PIN_OE == 4'h0 && !MATCH_FLAG) else $error("not clear after reset");
    a_ctrl_readback: assert property (WR && ADDR == OFF_UNIT_CTRL ##2
        RD && ADDR == OFF_UNIT_CTRL |=> RDATA == $past(WDATA, 3))
        else $error("control readback differs");
    a_dir_enable: assert property (WR && ADDR == OFF_PORT_DIR |=>
        PIN_OE == ~$past(wlow)) else $error("enable not from direction");
    a_port_modes: assert property (mode inside {0, 1, 3, [4:7], 4'hA}
        |-> PIN_OUT == latch) else $error("pins not port pins");
    a_bd_nonpwm: assert property (mode[3:2] != 2'b11 |->
        PIN_OUT[3:1] == latch[3:1]) else $error("B-D not port pins");
    a_flag_cause: assert property ($rose(MATCH_FLAG) |->
        $past(mode) inside {2, [4:4'hB]}) else $error("flag without cause");
    a_special_mode: assert property ($rose(TIMER_RESET) |->
        $past(mode) == MODE_CMP_SPECIAL) else $error("stray timer reset");
    a_convert_gate: assert property (TIMER_RESET || CONVERT_START |->
        CONVERT_START == (TIMER_RESET && $past(CONVERTER_ENABLE)))
        else $error("conversion start not gated");
    a_pulse_once: assert property (TIMER_RESET |=> !TIMER_RESET)
        else $error("timer reset longer than one cycle");
    cover property ($rose(MATCH_FLAG));
    cover property (TIMER_RESET && CONVERT_START);
    cover property (mode[3:2] == 2'b11 && PIN_OUT[3]);
endmodule
bind enhanced_waveform_unit_unit enhanced_waveform_unit_unit_properties enhanced_waveform_unit_unit_properties_i (
    .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .CONVERTER_ENABLE(CONVERTER_ENABLE),
    .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .MATCH_FLAG(MATCH_FLAG),
    .TIMER_RESET(TIMER_RESET), .CONVERT_START(CONVERT_START));

// File: bench/enhanced_waveform_unit_unit_bench.sv
// Bench: register, PWM, steering, compare and capture tests.
// Assumes the checker is bound in and the load model closes the pins.
`timescale 1ns/1ns
module enhanced_waveform_unit_unit_bench;
    import enhanced_waveform_unit_pkg::*;
    logic        CLK = 0, RESET = 1, WR = 0, RD = 0, ext = 0, tr, cs;
    logic        CONVERTER_ENABLE = 0;
    logic [3:0]  ADDR = 0;
    logic [7:0]  WDATA = 0;
    logic [15:0] CAPTURE_TIMER = 0;
    wire  [7:0]  RDATA;
    wire  [3:0]  PIN_IN, PIN_OUT, PIN_OE;
    wire         MATCH_FLAG, TIMER_RESET, CONVERT_START;
    int          errors = 0, comparisons = 0, cnt[4];
    int          cap_n[4] = '{1, 1, 4, 16};
    int          tab[4][4] = '{'{24, -1, -1, -1}, '{64, 0, 0, 24},
                               '{24, 40, -1, -1}, '{0, 24, 64, 0}};
    logic [3:0]  cmp_md[8] = '{8, 9, 2, 4'hB, 4'hB, 4'hA, 1, 3};
    logic        cmp_pin[8] = '{1, 0, 1, 1, 1, 0, 0, 0};
    logic        cmp_flag[8] = '{1, 1, 1, 1, 1, 1, 0, 0};
    enhanced_waveform_unit_unit enhanced_waveform_unit_unit_i (.CLK(CLK), .RESET(RESET), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .CAPTURE_TIMER(CAPTURE_TIMER), .CONVERTER_ENABLE(CONVERTER_ENABLE),
        .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
        .MATCH_FLAG(MATCH_FLAG), .TIMER_RESET(TIMER_RESET),
        .CONVERT_START(CONVERT_START));
    switch_load switch_load_i (.pin_out(PIN_OUT), .pin_oe(PIN_OE),
        .ext_level(ext), .pin_level(PIN_IN));
    initial forever #20 CLK = ~CLK;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // A gap cycle follows each strobe so no strobe is set twice per step
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1;
        @(posedge CLK);
        WR <= 0;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        ADDR <= a;
        RD <= 1;
        @(posedge CLK);
        RD <= 0;
        #1;
        check(16'(RDATA), 16'(exp));
        @(posedge CLK);
    endtask
    task automatic measure(input int n);
        cnt = '{default: 0};
        repeat (n) begin
            @(posedge CLK);
            #1;
            for (int p = 0; p < 4; p++) cnt[p] += int'(PIN_IN[p]);
        end
    endtask
    task automatic pulse;
        ext <= 1;
        repeat (4) @(posedge CLK);
        ext <= 0;
        repeat (4) @(posedge CLK);
        #1;
    endtask
    // Two periods are measured after three have settled the buffers
    task automatic pwm_run(input logic [1:0] ps, input logic [7:0] dl,
                           input logic [1:0] lsb, input int hi);
        int div;
        div = ps == 0 ? 1 : ps == 1 ? 4 : 16;
        wr(OFF_DUTY_LOW, dl);
        wr(OFF_TIMER_CTRL, {6'h01, ps});
        // Clears the prescaler, which may stand above a smaller new limit
        wr(OFF_TIMER_COUNT, 8'h00);
        wr(OFF_UNIT_CTRL, {2'b00, lsb, 4'hC});
        repeat (48 * div) @(posedge CLK);
        measure(32 * div);
        check(16'(cnt[0]), 16'(hi * div));
    endtask
    function automatic int pwm_exp(input int m, input int p);
        int t;
        t = tab[m / 4][p];
        if (t < 0) return 0;
        return m[(p % 2 == 0) ? 1 : 0] ? 64 - t : t;
    endfunction
    initial begin
        repeat (30000) @(posedge CLK);
        errors++;
        test_done();
    end
    initial begin
        repeat (20) @(posedge CLK);
        RESET <= 0;
        @(posedge CLK);
        for (int a = 0; a < 10; a++)
            rd(a[3:0], a == 1 ? 8'hFF : a == 8 ? 8'h0F : 8'h00);
        wr(OFF_UNIT_CTRL, 8'hA5);
        rd(OFF_UNIT_CTRL, 8'hA5);
        $display("test registers done");
        wr(OFF_PERIOD_LIMIT, 8'h03);
        wr(OFF_PORT_DIR, 8'h00);
        check(16'(PIN_OE), 16'hF);
        pwm_run(0, 8'h01, 2'h2, 12);
        pwm_run(0, 8'h01, 2'h1, 10);
        pwm_run(0, 8'h10, 2'h2, 32);
        pwm_run(0, 8'h00, 2'h0, 0);
        for (int p = 1; p < 5; p++) pwm_run(p[1:0], 8'h01, 2'h2, 12);
        $display("test duty done");
        for (int m = 0; m < 16; m++) begin
            wr(OFF_UNIT_CTRL, {m[3:2], 4'hB, m[1:0]});
            repeat (40) @(posedge CLK);
            measure(64);
            for (int p = 0; p < 4; p++)
                check(16'(cnt[p]), 16'(pwm_exp(m, p)));
        end
        $display("test steering done");
        wr(OFF_UNIT_CTRL, 8'h00);
        wr(OFF_DUTY_BUFFER, 8'h12);
        wr(OFF_DUTY_LOW, 8'h34);
        // Latch differs from the compare level, so port pins show apart
        wr(OFF_PORT_LATCH, 8'h00);
        foreach (cmp_md[i]) begin
            CAPTURE_TIMER <= 0;
            CONVERTER_ENABLE <= (i != 4);
            wr(OFF_UNIT_CTRL, {4'h0, cmp_md[i]});
            CAPTURE_TIMER <= 16'h1234;
            tr = 0;
            cs = 0;
            repeat (4) begin
                @(posedge CLK);
                #1;
                tr |= TIMER_RESET;
                cs |= CONVERT_START;
            end
            check(16'(PIN_OUT[0]), 16'(cmp_pin[i]));
            check(16'(MATCH_FLAG), 16'(cmp_flag[i]));
            check(16'(tr), 16'(cmp_md[i] == 4'hB));
            check(16'(cs), 16'(cmp_md[i] == 4'hB && i != 4));
            wr(OFF_STATUS, 8'h01);
        end
        $display("test compare done");
        wr(OFF_PORT_DIR, 8'h01);
        foreach (cap_n[i]) begin
            wr(OFF_UNIT_CTRL, 8'h00);
            wr(OFF_UNIT_CTRL, 8'(4 + i));
            CAPTURE_TIMER <= {8'hC0, 8'(i)};
            repeat (cap_n[i] - 1) pulse();
            check(16'(MATCH_FLAG), 16'h0);
            pulse();
            check(16'(MATCH_FLAG), 16'h1);
            rd(OFF_DUTY_LOW, 8'(i));
            rd(OFF_DUTY_BUFFER, 8'hC0);
            wr(OFF_STATUS, 8'h01);
        end
        $display("test capture done");
        test_done();
    end
endmodule
